// ==== design/mtco_channel_flags.sv ====
`timescale 1ns/1ps
module mtco_channel_flags (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic event_in,
  input wire logic clear_wr,
  output logic event_flag,
  output logic overrun_flag
);
  import mtco_pkg::*;
  logic ev_r, ev_nxt, ov_r, ov_nxt;

  always_comb begin
    ev_nxt = ev_r;
    ov_nxt = ov_r;
    if (clear_wr) begin
      ev_nxt = 1'b0;
      ov_nxt = 1'b0;
    end
    // Set beats clear so an event in the clearing cycle is kept
    if (event_in) begin
      ev_nxt = 1'b1;
      if (ev_r) begin
        ov_nxt = 1'b1;
      end
    end
    if (!run) begin
      ev_nxt = 1'b0;
      ov_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ev_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      ev_r <= ev_nxt;
      ov_r <= ov_nxt;
    end
  end

  assign event_flag = ev_r;
  assign overrun_flag = ov_r;

  ovr_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && event_in && ev_r |=> ov_r)
    else $error("overrun not set on repeat event");
  ovr_clr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && clear_wr && !event_in |=> !ov_r && !ev_r)
    else $error("overrun not cleared with event flag");
  ovr_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !run |=> !ov_r)
    else $error("overrun kept while stopped");
  ev_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && event_in |=> ev_r)
    else $error("event flag not set");
endmodule

// ==== design/mtco_pkg.sv ====
package mtco_pkg;
  // ---------------------------------------------
  // Indirect window
  // ---------------------------------------------
  localparam logic [2:0] MTCO_SA_CTRL = 3'h0;
  localparam logic [2:0] MTCO_SA_STAT = 3'h1;
  localparam logic [1:0] MTCO_WIN_0 = 2'h0;
  localparam logic [1:0] MTCO_WIN_1 = 2'h1;
  // ---------------------------------------------
  // Control register fields
  // ---------------------------------------------
  localparam int MTCO_RUN_POS = 7;
  localparam int MTCO_DIV_LSB = 3;
  localparam int MTCO_DIV_MSB = 5;
  localparam int MTCO_PAT_LSB = 0;
  localparam int MTCO_PAT_MSB = 1;
  localparam logic [7:0] MTCO_CTRL_WMASK = 8'hBB;
  localparam logic [7:0] MTCO_CTRL_RST = 8'h00;
  localparam logic [7:0] MTCO_STAT_RST = 8'h00;
  localparam logic [3:0] MTCO_FLAG_RST = 4'h0;
  localparam logic [15:0] MTCO_CNT_RST = 16'h0000;
  localparam logic [6:0] MTCO_PRE_RST = 7'h00;
  localparam int MTCO_NCH = 4;
  // ---------------------------------------------
  // Counting patterns
  // ---------------------------------------------
  localparam logic [1:0] MTCO_PAT_MODULO = 2'h0;
  localparam logic [1:0] MTCO_PAT_UPDOWN = 2'h2;
endpackage

// ==== design/mtco_timer.sv ====
`timescale 1ns/1ps
module mtco_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] sel_wdata,
  input wire logic sel_wr,
  input wire logic [1:0] win_idx,
  input wire logic win_wr,
  input wire logic win_rd,
  input wire logic [7:0] win_wdata,
  input wire logic [3:0] flag_clr_wr,
  input wire logic [3:0] chan_event,
  input wire logic [15:0] reload_val,
  input wire logic ext_clk_sel,
  input wire logic ext_tick,
  output logic [7:0] win_rdata,
  output logic [15:0] count_val,
  output logic timer_run_bit,
  output logic cycle_end,
  output logic [3:0] channel_event_flag,
  output logic [3:0] channel_overrun_flag
);
  import mtco_pkg::*;

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [2:0] sel_r, sel_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [2:0] div_act_r, div_act_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic dir_down_r, dir_down_nxt;
  logic end_r, end_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic ext_s1_r, ext_s2_r;
  logic [3:0] ev_flags, ov_flags;
  logic [3:0] ev_q_r, ov_q_r;
  logic [6:0] div_mask;
  logic tick, run, at_end;
  logic [1:0] pat;

  assign run = ctrl_r[MTCO_RUN_POS];
  assign pat = ctrl_r[MTCO_PAT_MSB:MTCO_PAT_LSB];
  assign div_mask = 7'((8'h01 << div_act_r) - 8'h01);

  // ---------------------------------------------
  // Prescaler and tick
  // ---------------------------------------------
  // Pin tick is a foreign level, so it is resynchronised first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_tick;
      ext_s2_r <= ext_s1_r;
    end
  end

  always_comb begin
    tick = 1'b0;
    pre_nxt = pre_r;
    if (!run) begin
      pre_nxt = MTCO_PRE_RST;
    end else if (ext_clk_sel) begin
      tick = ext_s2_r;
    end else if ((pre_r & div_mask) == div_mask) begin
      tick = 1'b1;
      pre_nxt = MTCO_PRE_RST;
    end else begin
      pre_nxt = 7'(pre_r + 7'h01);
    end
  end

  // ---------------------------------------------
  // Counter
  // ---------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    dir_down_nxt = dir_down_r;
    at_end = 1'b0;
    if (!run) begin
      cnt_nxt = MTCO_CNT_RST;
      dir_down_nxt = 1'b0;
    end else if (tick) begin
      if (pat == MTCO_PAT_UPDOWN) begin
        if (!dir_down_r) begin
          if (cnt_r >= reload_val) begin
            dir_down_nxt = 1'b1;
            cnt_nxt = 16'(cnt_r - 16'h0001);
          end else begin
            cnt_nxt = 16'(cnt_r + 16'h0001);
          end
        end else if (cnt_r == MTCO_CNT_RST) begin
          at_end = 1'b1;
          dir_down_nxt = 1'b0;
          cnt_nxt = 16'h0001;
        end else begin
          cnt_nxt = 16'(cnt_r - 16'h0001);
        end
      end else if (cnt_r >= reload_val) begin
        at_end = 1'b1;
        cnt_nxt = MTCO_CNT_RST;
      end else begin
        // Reserved codes fall back to modulo counting
        cnt_nxt = 16'(cnt_r + 16'h0001);
      end
    end
    end_nxt = at_end;
  end

  // ---------------------------------------------
  // Register window
  // ---------------------------------------------
  always_comb begin
    sel_nxt = sel_r;
    ctrl_nxt = ctrl_r;
    div_act_nxt = div_act_r;
    rd_nxt = rd_r;
    if (sel_wr) begin
      sel_nxt = sel_wdata;
    end
    if (win_wr && win_idx == MTCO_WIN_1 && sel_r == MTCO_SA_CTRL) begin
      ctrl_nxt = win_wdata & MTCO_CTRL_WMASK;
    end
    // Shadow divider follows freely when stopped, else only at cycle end
    if (!ctrl_nxt[MTCO_RUN_POS] || !run || at_end) begin
      div_act_nxt = ctrl_nxt[MTCO_DIV_MSB:MTCO_DIV_LSB];
    end
    if (win_rd) begin
      rd_nxt = 8'h00;
      if (win_idx == MTCO_WIN_0 && sel_r == MTCO_SA_STAT) begin
        rd_nxt = {4'h0, ov_flags};
      end else if (win_idx == MTCO_WIN_1 && sel_r == MTCO_SA_CTRL) begin
        rd_nxt = ctrl_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_r <= MTCO_SA_CTRL;
      ctrl_r <= MTCO_CTRL_RST;
      div_act_r <= MTCO_CTRL_RST[MTCO_DIV_MSB:MTCO_DIV_LSB];
      pre_r <= MTCO_PRE_RST;
      cnt_r <= MTCO_CNT_RST;
      dir_down_r <= 1'b0;
      end_r <= 1'b0;
      rd_r <= MTCO_STAT_RST;
      ev_q_r <= MTCO_FLAG_RST;
      ov_q_r <= MTCO_FLAG_RST;
    end else begin
      sel_r <= sel_nxt;
      ctrl_r <= ctrl_nxt;
      div_act_r <= div_act_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      dir_down_r <= dir_down_nxt;
      end_r <= end_nxt;
      rd_r <= rd_nxt;
      ev_q_r <= ev_flags;
      ov_q_r <= ov_flags;
    end
  end

  // ---------------------------------------------
  // Channel flags
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < MTCO_NCH; g++) begin : g_ch
      mtco_channel_flags u_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(run),
        .event_in(chan_event[g]),
        .clear_wr(flag_clr_wr[g]),
        .event_flag(ev_flags[g]),
        .overrun_flag(ov_flags[g])
      );
    end
  endgenerate

  assign win_rdata = rd_r;
  assign count_val = cnt_r;
  assign timer_run_bit = run;
  assign cycle_end = end_r;
  assign channel_event_flag = ev_q_r;
  assign channel_overrun_flag = ov_q_r;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  sequence run_drop_s;
    $fell(run);
  endsequence

  stop_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !run |=> cnt_r == MTCO_CNT_RST)
    else $error("counter not held while stopped");
  count_adv_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && !ext_clk_sel && div_act_r == 3'h0 && $stable(run)
      && cnt_r < reload_val && pat == MTCO_PAT_MODULO |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not advance");
  modulo_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && tick && pat == MTCO_PAT_MODULO && cnt_r >= reload_val |=> cnt_r == 16'h0000)
    else $error("modulo wrap missing");
  updown_turn_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && tick && pat == MTCO_PAT_UPDOWN && !dir_down_r && cnt_r >= reload_val |=> dir_down_r)
    else $error("up/down turn missing");
  // A write that stops the timer may load the divider at once
  div_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run && $stable(run) && !at_end |=> !run || div_act_r == $past(div_act_r))
    else $error("divider changed mid cycle");
  stat_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    win_rd && win_idx == MTCO_WIN_0 && sel_r == MTCO_SA_STAT |=> win_rdata[7:4] == 4'h0)
    else $error("reserved status bits nonzero");
  ctrl_resv_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |-> ctrl_r[6] == 1'b0 && ctrl_r[2] == 1'b0)
    else $error("reserved control bits set");
  stop_flags_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    run_drop_s |-> ##2 ov_q_r == 4'h0)
    else $error("overrun flags survive stop");
endmodule

// ==== tb/mtco_timer_tb.sv ====
`timescale 1ns/1ps
module mtco_timer_tb;
  import mtco_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] sel_wdata = 3'h0;
  logic sel_wr = 1'b0;
  logic [1:0] win_idx = 2'h0;
  logic win_wr = 1'b0;
  logic win_rd = 1'b0;
  logic [7:0] win_wdata = 8'h00;
  logic [3:0] flag_clr_wr = 4'h0;
  logic [3:0] chan_event = 4'h0;
  logic [15:0] reload_val = 16'h0006;
  logic ext_clk_sel = 1'b0;
  logic ext_tick = 1'b0;
  logic [7:0] win_rdata;
  logic [15:0] count_val;
  logic timer_run_bit;
  logic cycle_end;
  logic [3:0] channel_event_flag;
  logic [3:0] channel_overrun_flag;
  int fails = 0;
  int compares = 0;
  int ticks = 0;
  int n;
  logic [31:0] seed = 32'hDEB3;
  logic [7:0] rd, m, mp;
  logic [3:0] ev, cl;
  logic [15:0] p;
  logic up, e1;
  mtco_timer dut (.core_clk(core_clk), .sys_rst(sys_rst), .sel_wdata(sel_wdata),
    .sel_wr(sel_wr), .win_idx(win_idx), .win_wr(win_wr), .win_rd(win_rd),
    .win_wdata(win_wdata), .flag_clr_wr(flag_clr_wr), .chan_event(chan_event),
    .reload_val(reload_val), .ext_clk_sel(ext_clk_sel), .ext_tick(ext_tick),
    .win_rdata(win_rdata), .count_val(count_val), .timer_run_bit(timer_run_bit),
    .cycle_end(cycle_end), .channel_event_flag(channel_event_flag),
    .channel_overrun_flag(channel_overrun_flag));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      fails = fails + 1;
      wrap_up();
    end
  end
  // ---------------------------------------------
  // Models and helpers
  // ---------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Reserved codes fall back to modulo
  function automatic logic [16:0] next_cnt(logic [15:0] c, logic u, logic [1:0] pat);
    if (pat != MTCO_PAT_UPDOWN) return {1'b1, (c >= reload_val) ? 16'h0000 : c + 16'h1};
    if (u && c >= reload_val) u = 1'b0;
    else if (!u && c == 16'h0000) u = 1'b1;
    return {u, u ? c + 16'h1 : c - 16'h1};
  endfunction
  function automatic logic [7:0] next_flags(logic [7:0] f, logic [3:0] e, logic [3:0] c);
    return {(f[7:4] & ~c) | e, (f[3:0] & ~c) | (e & f[7:4])};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [2:0] s, input logic [1:0] w, input logic [7:0] d, input bit r);
    sel_wr = 1'b1;
    sel_wdata = s;
    @(negedge core_clk);
    sel_wr = 1'b0;
    win_idx = w;
    win_wdata = d;
    win_wr = !r;
    win_rd = r;
    @(negedge core_clk);
    win_wr = 1'b0;
    win_rd = 1'b0;
    @(negedge core_clk);
    rd = win_rdata;
  endtask
  // Second interval is measured, the first only finds a tick boundary
  task automatic gap(output int g);
    for (int k = 0; k < 2; k++) begin
      p = count_val;
      g = 0;
      while (count_val === p && g < 300) begin
        @(negedge core_clk);
        g++;
      end
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    chk16(count_val, MTCO_CNT_RST);
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b1);
    chk8(rd, MTCO_CTRL_RST);
    acc(MTCO_SA_STAT, MTCO_WIN_0, 8'h00, 1'b1);
    chk8(rd, MTCO_STAT_RST);
    acc(3'h5, MTCO_WIN_0, 8'h00, 1'b1);
    chk8(rd, 8'h00);
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h7C, 1'b0);
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b1);
    chk8(rd, 8'h38);
    for (int pat = 0; pat < 4; pat++) begin
      acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b0);
      repeat (3) @(negedge core_clk);
      chk16(count_val, MTCO_CNT_RST);
      acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h80 | pat[7:0], 1'b0);
      chk8({7'h00, timer_run_bit}, 8'h01);
      p = count_val;
      up = 1'b1;
      repeat (30) begin
        @(negedge core_clk);
        e1 = (pat == 2) ? (!up && p == 16'h0000) : (p >= reload_val);
        {up, p} = next_cnt(p, up, pat[1:0]);
        chk16(count_val, p);
        chk8({7'h00, cycle_end}, {7'h00, e1});
      end
    end
    reload_val = 16'hFFFF;
    for (int d = 0; d < 8; d++) begin
      acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b0);
      acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h80 | 8'(d << 3), 1'b0);
      gap(n);
      chk16(16'(n), 16'(1 << d));
    end
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h80, 1'b0);
    gap(n);
    chk16(16'(n), 16'h0080);
    reload_val = 16'h0002;
    repeat (400) @(negedge core_clk);
    gap(n);
    chk16(16'(n), 16'h0001);
    ext_clk_sel = 1'b1;
    reload_val = 16'hFFFF;
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b0);
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'hB8, 1'b0);
    repeat (3) begin
      ext_tick = 1'b1;
      @(negedge core_clk);
      ext_tick = 1'b0;
      repeat (5) @(negedge core_clk);
    end
    repeat (4) @(negedge core_clk);
    chk16(count_val, 16'h0003);
    ext_clk_sel = 1'b0;
    acc(MTCO_SA_STAT, MTCO_WIN_1, 8'h00, 1'b0);
    chk8({7'h00, timer_run_bit}, 8'h01);
    m = 8'h00;
    mp = 8'h00;
    // Clear and event may meet on one channel; the event then wins
    repeat (300) begin
      seed = xs(seed);
      ev = seed[3:0] & seed[7:4];
      cl = seed[11:8] & seed[15:12];
      chk8({channel_event_flag, channel_overrun_flag}, mp);
      mp = m;
      m = next_flags(m, ev, cl);
      chan_event = ev;
      flag_clr_wr = cl;
      @(negedge core_clk);
    end
    chan_event = 4'h0;
    flag_clr_wr = 4'h0;
    acc(MTCO_SA_STAT, MTCO_WIN_0, 8'h00, 1'b1);
    chk8(rd, {4'h0, m[3:0]});
    acc(MTCO_SA_CTRL, MTCO_WIN_1, 8'h00, 1'b0);
    repeat (2) @(negedge core_clk);
    chk8({channel_event_flag, channel_overrun_flag}, 8'h00);
    wrap_up();
  end
endmodule
